// ==== logic/ral_defs.svh ====
/*
  Constants of the runtime alarm logger: offsets, field positions, reset values, counts.
  Assumes a 200 MHz pclk and a 12-bit APB byte address.
*/
`ifndef RAL_DEFS_SVH
`define RAL_DEFS_SVH
`define RAL_CLK_PERIOD_NS 5
`define RAL_TICK_NS 1000000
`define RAL_CYC_PER_MS (`RAL_TICK_NS / `RAL_CLK_PERIOD_NS)
`define RAL_MS_PER_DAY 32'd86400000
`define RAL_BUF_DEPTH 8
`define RAL_HIST_DEPTH 6'd56
`define RAL_HIST_BASE 6'd8
`define RAL_OVR_SLOT 3'd6
`define RAL_ACTIVE_BIT 7
`define RAL_BUSY_BIT 0
`define RAL_OFF_RT_MS 12'h000
`define RAL_OFF_RT_DAYS 12'h004
`define RAL_OFF_STATUS 12'h008
`define RAL_OFF_COUNTER 12'h00c
`define RAL_OFF_LATEST 12'h010
`define RAL_OFF_SELECT 12'h014
`define RAL_OFF_ENT_BASE 12'h018
`define RAL_OFF_ENT_LAST 12'h030
`define RAL_OFF_HCOUNT 12'h034
`define RAL_RST_WORD 32'h0000_0000
`define RAL_RST_HEAD 6'h37
`endif

// ==== logic/ral_pkg.sv ====
/*
  Types of the runtime alarm logger.
  Assumes the constants header is compiled alongside.
*/
package ral_pkg;
  // One logged alarm
  typedef struct packed {
    logic [15:0] code;
    logic [31:0] vfix;
    logic [31:0] vflt;
    logic [31:0] rx_days;
    logic [31:0] rx_ms;
    logic [31:0] rm_days;
    logic [31:0] rm_ms;
  } ral_entry_t;
  typedef enum logic {RAL_EVT_RAISE, RAL_EVT_GONE} ral_evt_t;
  typedef enum logic [1:0] {RAL_IDLE, RAL_SCAN, RAL_PACK, RAL_STORE} ral_state_t;
endpackage

// ==== logic/ral_ifs.sv ====
/*
  Carriers between logger modules: runtime words and history memory port.
  Assumes all parties share pclk.
*/
`timescale 1ns/1ps
interface ral_time_if;
  logic [31:0] ms;
  logic [31:0] days;
  modport src (output ms, output days);
  modport dst (input ms, input days);
endinterface
interface ral_hist_if;
  logic wr_en;
  logic [5:0] wr_addr;
  ral_pkg::ral_entry_t wr_data;
  logic [5:0] rd_addr;
  ral_pkg::ral_entry_t rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// ==== logic/ral_runtime.sv ====
/*
  Runtime counter: ms-of-day and days words with a ms prescaler.
  Assumes presetn is the power-on reset and nothing else can clear it.
*/
`timescale 1ns/1ps
`include "ral_defs.svh"
module ral_runtime #(
  parameter int unsigned CYCLES_PER_MS = `RAL_CYC_PER_MS
) (
  input wire logic pclk, // Device clock
  input wire logic presetn, // Power-on reset, active low
  ral_time_if.src rt // Runtime words out
);
  logic [31:0] pre_reg;
  logic [31:0] ms_reg;
  logic [31:0] days_reg;
  wire tick = (pre_reg == 32'(CYCLES_PER_MS - 1));
  wire day_end = (ms_reg == `RAL_MS_PER_DAY - 32'd1);
  ////////////////////////////////////////////////////////////////
  // Both words change on one edge so a capture never sees a half update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= `RAL_RST_WORD;
      ms_reg <= `RAL_RST_WORD;
      days_reg <= `RAL_RST_WORD;
    end else begin
      pre_reg <= tick ? `RAL_RST_WORD : pre_reg + 32'd1;
      if (tick) begin
        ms_reg <= day_end ? `RAL_RST_WORD : ms_reg + 32'd1;
        days_reg <= day_end ? days_reg + 32'd1 : days_reg;
      end
    end
  end
  assign rt.ms = ms_reg;
  assign rt.days = days_reg;
endmodule // ral_runtime

// ==== logic/ral_hist_mem.sv ====
/*
  History store: 56 entries, one write and one registered read port.
  Assumes addresses below 56; contents are undefined until written.
*/
`timescale 1ns/1ps
`include "ral_defs.svh"
module ral_hist_mem (
  input wire logic pclk, // Device clock
  input wire logic presetn, // Reset, clears the read register only
  ral_hist_if.mem hp // Memory port
);
  ral_pkg::ral_entry_t mem [56];
  ////////////////////////////////////////////////////////////////
  // Array has no reset; unused slots are masked by the occupancy count
  always_ff @(posedge pclk) begin
    if (hp.wr_en) begin
      mem[hp.wr_addr] <= hp.wr_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp.rd_data <= '0;
    end else begin
      hp.rd_data <= mem[hp.rd_addr];
    end
  end
endmodule // ral_hist_mem

// ==== logic/ral_logger.sv ====
/*
  Runtime alarm logger top: runtime, eight-entry alarm buffer, 56-entry history,
  APB register slave.
  Assumes an APB3 master on pclk and an alarm source that holds a request until ready.
*/
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "ral_defs.svh"
module ral_logger #(
  parameter int unsigned CYCLES_PER_MS = `RAL_CYC_PER_MS
) (
  input wire logic pclk, // Device clock, 200 MHz
  input wire logic presetn, // Power-on reset, active low
  input wire logic [11:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic evt_valid, // Alarm event request
  output logic evt_ready, // Event accepted when both high
  input wire logic evt_kind, // 0 raise, 1 cause gone
  input wire logic [15:0] evt_code, // Alarm code
  input wire logic [31:0] evt_value_fixed, // Value, fixed-point
  input wire logic [31:0] evt_value_float, // Value, floating-point
  output logic alarm_active // Any alarm active
);

  ////////////////////////////////////////////////////////////////
  // Declarations
  ral_time_if rt ();
  ral_hist_if hp ();
  ral_pkg::ral_state_t state_reg;
  ral_pkg::ral_state_t state_next;
  ral_pkg::ral_entry_t buf_reg [8];
  ral_pkg::ral_entry_t buf_next [8];
  logic [7:0] bval_reg;
  logic [7:0] bval_next;
  logic [7:0] brem_reg;
  logic [7:0] brem_next;
  logic [2:0] scan_reg;
  logic [2:0] scan_next;
  ral_pkg::ral_entry_t pend_reg;
  ral_pkg::ral_entry_t pend_next;
  logic pend_raise_reg;
  logic pend_raise_next;
  logic flush_req_reg;
  logic [31:0] cnt_reg;
  logic [15:0] latest_reg;
  logic [5:0] sel_reg;
  logic [5:0] head_reg;
  logic [5:0] hcnt_reg;
  logic [31:0] prdata_reg;
  logic active_reg;
  logic gone_hit;
  logic [2:0] gone_idx;

  ////////////////////////////////////////////////////////////////
  // Functions

  // Number of occupied buffer slots; the buffer is kept packed from slot 0
  function automatic logic [3:0] fill_of(input logic [7:0] v);
    logic [3:0] n;
    n = 4'd0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'd0, v[i]};
    end
    return n;
  endfunction

  // One 32-bit field of an entry, used for buffer and history reads
  function automatic logic [31:0] entry_field(input ral_pkg::ral_entry_t e,
                                              input logic [2:0] f);
    case (f)
      3'h0: entry_field = {16'h0000, e.code};
      3'h1: entry_field = e.vfix;
      3'h2: entry_field = e.vflt;
      3'h3: entry_field = e.rx_days;
      3'h4: entry_field = e.rx_ms;
      3'h5: entry_field = e.rm_days;
      3'h6: entry_field = e.rm_ms;
      default: entry_field = `RAL_RST_WORD;
    endcase
  endfunction

  // Physical slot k places back from the newest, modulo the history depth
  function automatic logic [5:0] hist_slot(input logic [5:0] head, input logic [5:0] k);
    logic [6:0] s;
    s = (head >= k) ? {1'b0, head} - {1'b0, k} : {1'b0, head} + {1'b0, `RAL_HIST_DEPTH}
        - {1'b0, k};
    return s[5:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // Runtime and history store
  ral_runtime #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_runtime (
    .pclk(pclk),
    .presetn(presetn),
    .rt(rt.src)
  );

  ral_hist_mem u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .hp(hp.mem)
  );

  ////////////////////////////////////////////////////////////////
  // Event decode
  wire idle = (state_reg == ral_pkg::RAL_IDLE);
  wire take = evt_valid & idle;
  wire raise_take = take & (evt_kind == ral_pkg::RAL_EVT_RAISE);
  wire gone_take = take & (evt_kind == ral_pkg::RAL_EVT_GONE);
  wire [3:0] fill = fill_of(bval_reg);
  wire [2:0] fill_slot = fill[2:0];
  wire full = &bval_reg;
  wire any_removed = |(bval_reg & brem_reg);
  wire [7:0] active_vec = bval_reg & ~brem_reg;
  // Runtime sampled from flops, so both words belong to the same instant
  wire ral_pkg::ral_entry_t new_entry = '{code: evt_code, vfix: evt_value_fixed,
    vflt: evt_value_float, rx_days: rt.days, rx_ms: rt.ms,
    rm_days: `RAL_RST_WORD, rm_ms: `RAL_RST_WORD};

  // Oldest active entry carrying the code whose cause went away
  always_comb begin
    gone_hit = 1'b0;
    gone_idx = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (active_vec[i] && buf_reg[i].code == evt_code) begin
        gone_hit = 1'b1;
        gone_idx = 3'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire ent_hit = (paddr >= `RAL_OFF_ENT_BASE) && (paddr <= `RAL_OFF_ENT_LAST) &&
                 (paddr[1:0] == 2'b00);
  wire [11:0] ent_off = paddr - `RAL_OFF_ENT_BASE;
  wire [2:0] ent_fld = ent_off[4:2];
  wire addr_hit = ent_hit || paddr == `RAL_OFF_RT_MS || paddr == `RAL_OFF_RT_DAYS ||
                  paddr == `RAL_OFF_STATUS || paddr == `RAL_OFF_COUNTER ||
                  paddr == `RAL_OFF_LATEST || paddr == `RAL_OFF_SELECT ||
                  paddr == `RAL_OFF_HCOUNT;
  wire apb_wr = apb_access & pwrite & addr_hit;
  // Only zero is a meaningful counter write; other values are ignored
  wire wr_zero = apb_wr && paddr == `RAL_OFF_COUNTER && pwdata == `RAL_RST_WORD;
  wire wr_sel = apb_wr && paddr == `RAL_OFF_SELECT;
  // Runtime offsets decode but have no write path at all
  wire wr_runtime = apb_wr && (paddr == `RAL_OFF_RT_MS || paddr == `RAL_OFF_RT_DAYS);

  ////////////////////////////////////////////////////////////////
  // Entry view: index 0..7 is the buffer, 8..63 the history
  wire sel_hist = (sel_reg >= `RAL_HIST_BASE);
  wire [5:0] hist_k = sel_reg - `RAL_HIST_BASE; // 0 = youngest, at index 8
  wire hist_ok = sel_hist && (hist_k < hcnt_reg);
  wire buf_ok = !sel_hist && bval_reg[sel_reg[2:0]];
  wire [31:0] buf_word = buf_ok ? entry_field(buf_reg[sel_reg[2:0]], ent_fld) : `RAL_RST_WORD;
  wire [31:0] hist_word = hist_ok ? entry_field(hp.rd_data, ent_fld) : `RAL_RST_WORD;
  wire [31:0] status_word = {24'h0, active_reg, 6'h00, !idle};
  wire [31:0] rd_word =
    ent_hit ? (sel_hist ? hist_word : buf_word) :
    (paddr == `RAL_OFF_RT_MS) ? rt.ms :
    (paddr == `RAL_OFF_RT_DAYS) ? rt.days :
    (paddr == `RAL_OFF_STATUS) ? status_word :
    (paddr == `RAL_OFF_COUNTER) ? cnt_reg :
    (paddr == `RAL_OFF_LATEST) ? {16'h0000, latest_reg} :
    (paddr == `RAL_OFF_SELECT) ? {26'h0, sel_reg} :
    (paddr == `RAL_OFF_HCOUNT) ? {26'h0, hcnt_reg} : `RAL_RST_WORD;

  ////////////////////////////////////////////////////////////////
  // History port: a removed entry is pushed as the scan passes it
  wire push = (state_reg == ral_pkg::RAL_SCAN) && bval_reg[scan_reg] && brem_reg[scan_reg];
  wire [5:0] head_inc = (head_reg == `RAL_HIST_DEPTH - 6'd1) ? 6'd0 : head_reg + 6'd1;
  assign hp.wr_en = push;
  // Oldest buffer slot goes first, so the youngest ends up at index 8
  assign hp.wr_addr = head_inc;
  assign hp.wr_data = buf_reg[scan_reg];
  assign hp.rd_addr = hist_slot(head_reg, hist_k);

  ////////////////////////////////////////////////////////////////
  // Buffer and sequencer next state
  always_comb begin
    int unsigned j;
    j = 0;
    state_next = state_reg;
    buf_next = buf_reg;
    bval_next = bval_reg;
    brem_next = brem_reg;
    scan_next = scan_reg;
    pend_next = pend_reg;
    pend_raise_next = pend_raise_reg;
    case (state_reg)
      ral_pkg::RAL_IDLE: begin
        if (raise_take) begin
          if (!full) begin
            buf_next[fill_slot] = new_entry;
            bval_next[fill_slot] = 1'b1;
            brem_next[fill_slot] = 1'b0;
          end else if (any_removed) begin
            pend_next = new_entry;
            pend_raise_next = 1'b1;
            scan_next = 3'd0;
            state_next = ral_pkg::RAL_SCAN;
          end else begin
            buf_next[`RAL_OVR_SLOT] = new_entry;
            brem_next[`RAL_OVR_SLOT] = 1'b0;
          end
        end else if (gone_take) begin
          if (gone_hit) begin
            brem_next[gone_idx] = 1'b1;
            buf_next[gone_idx].rm_days = rt.days;
            buf_next[gone_idx].rm_ms = rt.ms;
          end
        end else if (flush_req_reg) begin
          pend_raise_next = 1'b0;
          scan_next = 3'd0;
          state_next = ral_pkg::RAL_SCAN;
        end
      end
      ral_pkg::RAL_SCAN: begin
        scan_next = scan_reg + 3'd1;
        if (scan_reg == 3'(`RAL_BUF_DEPTH - 1)) begin
          state_next = ral_pkg::RAL_PACK;
        end
      end
      ral_pkg::RAL_PACK: begin
        // Drop what went to history and close the gaps, keeping order
        bval_next = 8'h00;
        brem_next = 8'h00;
        for (int i = 0; i < 8; i++) begin
          buf_next[i] = '0;
        end
        for (int i = 0; i < 8; i++) begin
          if (active_vec[i]) begin
            buf_next[j[2:0]] = buf_reg[i];
            bval_next[j[2:0]] = 1'b1;
            j = j + 1;
          end
        end
        state_next = pend_raise_reg ? ral_pkg::RAL_STORE : ral_pkg::RAL_IDLE;
      end
      ral_pkg::RAL_STORE: begin
        buf_next[fill_slot] = pend_reg;
        bval_next[fill_slot] = 1'b1;
        brem_next[fill_slot] = 1'b0;
        pend_raise_next = 1'b0;
        state_next = ral_pkg::RAL_IDLE;
      end
      default: begin
        state_next = ral_pkg::RAL_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer and buffer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ral_pkg::RAL_IDLE;
      bval_reg <= 8'h00;
      brem_reg <= 8'h00;
      scan_reg <= 3'd0;
      pend_raise_reg <= 1'b0;
      pend_reg <= '0;
      for (int i = 0; i < 8; i++) begin
        buf_reg[i] <= '0;
      end
    end else begin
      state_reg <= state_next;
      bval_reg <= bval_next;
      brem_reg <= brem_next;
      scan_reg <= scan_next;
      pend_raise_reg <= pend_raise_next;
      pend_reg <= pend_next;
      buf_reg <= buf_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // History pointer; a full ring overwrites its oldest slot on a push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_reg <= `RAL_RST_HEAD;
      hcnt_reg <= 6'd0;
    end else if (push) begin
      head_reg <= head_inc;
      hcnt_reg <= (hcnt_reg == `RAL_HIST_DEPTH) ? hcnt_reg : hcnt_reg + 6'd1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Alarm counter and flush request; a raise in the clearing cycle still counts
  wire flush_start = idle && (state_next == ral_pkg::RAL_SCAN);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= `RAL_RST_WORD;
      flush_req_reg <= 1'b0;
      latest_reg <= 16'h0000;
    end else begin
      if (wr_zero) begin
        cnt_reg <= {31'd0, raise_take};
      end else if (raise_take) begin
        cnt_reg <= cnt_reg + 32'd1;
      end
      // A request written while a scan starts is kept for the next round
      flush_req_reg <= (flush_req_reg & ~flush_start) | wr_zero;
      if (raise_take) begin
        latest_reg <= evt_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB registers; runtime writes fall through untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= 6'd0;
      prdata_reg <= `RAL_RST_WORD;
      active_reg <= 1'b0;
    end else begin
      if (wr_sel && !wr_runtime) begin
        sel_reg <= pwdata[5:0];
      end
      if (apb_setup) begin
        prdata_reg <= rd_word;
      end
      // A raise parked during a transfer is active before it reaches the buffer
      active_reg <= |(bval_next & ~brem_next) | pend_raise_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs; every access completes in its first access cycle
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_hit;
  assign evt_ready = idle;
  assign alarm_active = active_reg;

endmodule // ral_logger

// ==== test/ral_logger_assertions.sv ====
/*
  Checker of the logger top: event handshake, active flag, flush timing, APB answers.
  Assumes it is bound to ral_logger and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "ral_defs.svh"
module ral_logger_assertions #(
  parameter int unsigned CYCLES_PER_MS = 4
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic evt_valid, // Event request
  input wire logic evt_ready, // Event accept
  input wire logic evt_kind, // Raise or gone
  input wire logic [15:0] evt_code, // Alarm code
  input wire logic [31:0] evt_value_fixed, // Value fixed
  input wire logic [31:0] evt_value_float, // Value float
  input wire logic alarm_active // Any alarm active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Named steps of bus and event traffic
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_flush_wr;
    s_access ##0 pwrite && paddr == `RAL_OFF_COUNTER && pwdata == 32'h0;
  endsequence
  sequence s_take(k);
    evt_valid && evt_ready && evt_kind == k;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // A gone event is the only way an active flag can fall
  a_raise_shows:
    assert property (s_take(1'b0) |=> alarm_active) else $error("flag low after raise");
  a_active_holds:
    assert property (alarm_active && !(evt_valid && evt_ready && evt_kind) |=> alarm_active)
      else $error("flag fell without gone event");
  a_quiet_low:
    assert property (!alarm_active && !(evt_valid && evt_ready && !evt_kind) |=> !alarm_active)
      else $error("flag rose without raise");
  a_flush_starts:
    assert property (s_flush_wr ##0 evt_ready |=> ##[0:1] !evt_ready)
      else $error("flush did not start");
  a_scan_span:
    assert property ($fell(evt_ready) |-> !evt_ready [*8] ##[1:4] evt_ready)
      else $error("transfer length wrong");
  a_read_stands:
    assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
  a_bad_addr:
    assert property (s_access ##0 paddr > `RAL_OFF_HCOUNT |-> pslverr && pready)
      else $error("unmapped access not refused");
  a_good_addr:
    assert property (s_access ##0 paddr <= `RAL_OFF_HCOUNT ##0 paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
  cover property (s_flush_wr);
endmodule // ral_logger_assertions
bind ral_logger ral_logger_assertions #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_ral_logger_assertions (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_kind(evt_kind), .evt_code(evt_code),
  .evt_value_fixed(evt_value_fixed), .evt_value_float(evt_value_float),
  .alarm_active(alarm_active));

// ==== test/ral_logger_test.sv ====
/*
  Self-checking bench of the logger top, driving APB and the event port directly.
  Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ps
`include "ral_defs.svh"
module ral_logger_test;
  localparam int unsigned CPM = 4; // Short tick keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic evt_valid = 1'b0;
  logic evt_ready;
  logic evt_kind = 1'b0;
  logic [15:0] evt_code = 16'h0;
  logic [31:0] evt_value_fixed = 32'h0;
  logic [31:0] evt_value_float = 32'h0;
  logic alarm_active;
  logic [31:0] v;
  logic [31:0] m0;
  logic [31:0] m1;
  logic err;
  int n_errors = 0;
  int n_tests = 0;
  ral_logger #(.CYCLES_PER_MS(CPM)) u_ral_logger (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_valid(evt_valid),
    .evt_ready(evt_ready), .evt_kind(evt_kind), .evt_code(evt_code),
    .evt_value_fixed(evt_value_fixed), .evt_value_float(evt_value_float),
    .alarm_active(alarm_active));
  // Clock, 5 ns period
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Shared drivers and the comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle edge after it keeps psel from toggling in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Entry view needs select written in a transfer of its own
  task automatic sel_rd(input logic [5:0] idx, input logic [11:0] off);
    apb(1'b1, `RAL_OFF_SELECT, {26'h0, idx});
    apb(1'b0, off, 32'h0);
  endtask
  task automatic evt(input logic kind, input logic [15:0] code);
    evt_valid <= 1'b1;
    evt_kind <= kind;
    evt_code <= code;
    evt_value_fixed <= {16'ha5a5, code};
    evt_value_float <= {code, 16'h3c00};
    @(posedge pclk);
    while (evt_ready !== 1'b1) @(posedge pclk);
    evt_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge pclk);
    while (evt_ready !== 1'b1) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    apb(1'b0, `RAL_OFF_STATUS, 32'h0);
    chk(v, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, `RAL_OFF_COUNTER, 32'h0);
    chk(v, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(v, 32'h0);
  endtask
  // Capture edges are 40 apart, so exactly ten ticks land between the reads
  task automatic t_runtime();
    apb(1'b0, `RAL_OFF_RT_MS, 32'h0);
    m0 = v;
    apb(1'b1, `RAL_OFF_RT_MS, 32'h0000_ffff);
    repeat (34) @(posedge pclk);
    apb(1'b0, `RAL_OFF_RT_MS, 32'h0);
    chk(v - m0, 32'd10);
    apb(1'b0, `RAL_OFF_RT_DAYS, 32'h0);
    chk(v, 32'h0);
  endtask
  task automatic t_fill();
    apb(1'b0, `RAL_OFF_RT_MS, 32'h0);
    m0 = v;
    evt(1'b0, 16'h1);
    apb(1'b0, `RAL_OFF_RT_MS, 32'h0);
    m1 = v;
    for (int i = 2; i <= 8; i++) begin
      evt(1'b0, i[15:0]);
    end
    chk({31'h0, alarm_active}, 32'h1);
    apb(1'b0, `RAL_OFF_STATUS, 32'h0);
    chk(v & 32'h80, 32'h80);
    apb(1'b0, `RAL_OFF_COUNTER, 32'h0);
    chk(v, 32'h8);
    apb(1'b0, `RAL_OFF_LATEST, 32'h0);
    chk(v, 32'h8);
    sel_rd(6'h0, `RAL_OFF_ENT_BASE);
    chk(v, 32'h1);
    sel_rd(6'h0, 12'h01c);
    chk(v, 32'ha5a5_0001);
    sel_rd(6'h0, 12'h020);
    chk(v, 32'h0001_3c00);
    sel_rd(6'h0, 12'h024);
    chk(v, 32'h0);
    sel_rd(6'h0, 12'h028);
    chk({31'h0, v >= m0 && v <= m1}, 32'h1);
    sel_rd(6'h0, `RAL_OFF_ENT_LAST);
    chk(v, 32'h0);
    sel_rd(6'h7, `RAL_OFF_ENT_BASE);
    chk(v, 32'h8);
    evt(1'b0, 16'h9);
    sel_rd(6'h6, `RAL_OFF_ENT_BASE);
    chk(v, 32'h9);
    sel_rd(6'h7, `RAL_OFF_ENT_BASE);
    chk(v, 32'h8);
  endtask
  // Two removed entries, then a raise into the full buffer moves them out
  task automatic t_transfer();
    apb(1'b0, `RAL_OFF_RT_MS, 32'h0);
    m0 = v;
    evt(1'b1, 16'h2);
    apb(1'b0, `RAL_OFF_RT_MS, 32'h0);
    m1 = v;
    evt(1'b1, 16'h4);
    chk({31'h0, alarm_active}, 32'h1);
    sel_rd(6'h1, `RAL_OFF_ENT_LAST);
    chk({31'h0, v >= m0 && v <= m1}, 32'h1);
    sel_rd(6'h1, `RAL_OFF_ENT_BASE);
    chk(v, 32'h2);
    evt(1'b0, 16'ha);
    wait_idle();
    apb(1'b0, `RAL_OFF_HCOUNT, 32'h0);
    chk(v, 32'h2);
    sel_rd(6'h8, `RAL_OFF_ENT_BASE);
    chk(v, 32'h4);
    sel_rd(6'h9, `RAL_OFF_ENT_BASE);
    chk(v, 32'h2);
    sel_rd(6'h1, `RAL_OFF_ENT_BASE);
    chk(v, 32'h3);
    sel_rd(6'h6, `RAL_OFF_ENT_BASE);
    chk(v, 32'ha);
    sel_rd(6'h7, `RAL_OFF_ENT_BASE);
    chk(v, 32'h0);
  endtask
  task automatic t_flush();
    evt(1'b1, 16'h1);
    apb(1'b1, `RAL_OFF_COUNTER, 32'h5);
    apb(1'b0, `RAL_OFF_COUNTER, 32'h0);
    chk(v, 32'ha);
    apb(1'b1, `RAL_OFF_COUNTER, 32'h0);
    // Busy is sampled in the first scan cycle, while the slots are still held
    apb(1'b0, `RAL_OFF_STATUS, 32'h0);
    chk(v, 32'h81);
    wait_idle();
    apb(1'b0, `RAL_OFF_COUNTER, 32'h0);
    chk(v, 32'h0);
    apb(1'b0, `RAL_OFF_HCOUNT, 32'h0);
    chk(v, 32'h3);
    sel_rd(6'h0, `RAL_OFF_ENT_BASE);
    chk(v, 32'h3);
  endtask
  // One-alarm flushes until the history is full and one push beyond it
  task automatic t_overflow();
    for (int i = 0; i < 54; i++) begin
      evt(1'b0, 16'h100 + i[15:0]);
      evt(1'b1, 16'h100 + i[15:0]);
      apb(1'b1, `RAL_OFF_COUNTER, 32'h0);
      wait_idle();
    end
    apb(1'b0, `RAL_OFF_HCOUNT, 32'h0);
    chk(v, 32'h38);
    sel_rd(6'h8, `RAL_OFF_ENT_BASE);
    chk(v, 32'h135);
    sel_rd(6'h3f, `RAL_OFF_ENT_BASE);
    chk(v, 32'h4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_runtime();
    t_fill();
    t_transfer();
    t_flush();
    t_overflow();
    conclude();
  end
endmodule // ral_logger_test
